// ### src/clksel_pkg.sv
package clksel_pkg;
   localparam int IR_LEN = 10;
   // Opcodes are arbitrary values chosen for this block
   localparam logic [IR_LEN-1:0] OPC_SELECT_USER = 10'h00e;
   localparam logic [IR_LEN-1:0] OPC_REVERT_OSC = 10'h00f;
   localparam logic [IR_LEN-1:0] OPC_BYPASS = 10'h3ff;
   localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 10'h001;
   localparam logic [3:0] REVERT_TAIL_EDGES = 4'ha;
   localparam int SYNC_W = 6;
   localparam int SY_TCK = 0;
   localparam int SY_TMS = 1;
   localparam int SY_TDI = 2;
   localparam int SY_UCLK = 3;
   localparam int SY_OSC = 4;
   localparam int SY_POR = 5;

   typedef enum logic [3:0] {
      TAP_RESET = 4'h0,
      TAP_IDLE = 4'h1,
      TAP_SEL_DR = 4'h2,
      TAP_CAP_DR = 4'h3,
      TAP_SHIFT_DR = 4'h4,
      TAP_EXIT1_DR = 4'h5,
      TAP_PAUSE_DR = 4'h6,
      TAP_EXIT2_DR = 4'h7,
      TAP_UPD_DR = 4'h8,
      TAP_SEL_IR = 4'h9,
      TAP_CAP_IR = 4'ha,
      TAP_SHIFT_IR = 4'hb,
      TAP_EXIT1_IR = 4'hc,
      TAP_PAUSE_IR = 4'hd,
      TAP_EXIT2_IR = 4'he,
      TAP_UPD_IR = 4'hf
   } tap_state_e;
endpackage : clksel_pkg

// ### src/pin_sync.sv
module pin_sync #(
   parameter int W = 1
) (
   input wire logic clock, // System clock
   input wire logic sys_rst, // Async reset, active high
   input wire logic [W-1:0] d_in, // Asynchronous pins
   output logic [W-1:0] q_out // Synchronised levels
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               meta_reg[i] <= 1'b0;
               sync_reg[i] <= 1'b0;
            end else begin
               meta_reg[i] <= d_in[i];
               sync_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

   assign q_out = sync_reg;
endmodule : pin_sync

// ### src/clock_source_select.sv
module clock_source_select
   import clksel_pkg::*;
(
   input wire logic clock, // 100 MHz system clock
   input wire logic sys_rst, // Async reset, active high
   input wire logic tck, // Test clock pin
   input wire logic tms, // Test mode select pin
   input wire logic tdi, // Test data in pin
   input wire logic user_clock_pin, // Board user clock pin
   input wire logic osc_enable, // Internal oscillator enabled
   input wire logic por, // Power-on reset event, active high
   output logic tdo, // Test data out
   output logic tdo_oe, // Drive enable for tdo
   output logic user_clk_latch, // User-clock enable latch
   output logic clk_src_user // 1: user clock pin is the source
);
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_s;
   logic tck_prev_reg, tck_prev_next;
   logic uclk_prev_reg, uclk_prev_next;
   logic tck_rise, tck_fall, uclk_rise, upd_ir;
   tap_state_e tap_reg, tap_next;
   logic [IR_LEN-1:0] ir_shift_reg, ir_shift_next;
   logic [IR_LEN-1:0] ir_reg, ir_next;
   logic bypass_reg, bypass_next;
   logic tdo_reg, tdo_next;
   logic tdo_oe_reg, tdo_oe_next;
   logic user_en_reg, user_en_next;
   logic src_user_reg, src_user_next;
   logic [3:0] tail_reg, tail_next;

   // Test clock is oversampled, so each tck phase needs several clocks
   assign pins_raw = {por, osc_enable, user_clock_pin, tdi, tms, tck};

   pin_sync #(.W(SYNC_W)) u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .d_in(pins_raw),
      .q_out(pins_s)
   );

   assign tck_rise = pins_s[SY_TCK] & ~tck_prev_reg;
   assign tck_fall = ~pins_s[SY_TCK] & tck_prev_reg;
   assign uclk_rise = pins_s[SY_UCLK] & ~uclk_prev_reg;
   assign upd_ir = tck_rise && (tap_reg == TAP_UPD_IR);

   // Test access port state walk, advanced on each sampled tck rise
   always_comb begin
      tap_next = tap_reg;
      if (tck_rise) begin
         unique case (tap_reg)
            TAP_RESET: tap_next = pins_s[SY_TMS] ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_next = pins_s[SY_TMS] ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = pins_s[SY_TMS] ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = pins_s[SY_TMS] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_next = pins_s[SY_TMS] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_next = pins_s[SY_TMS] ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = pins_s[SY_TMS] ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_next = pins_s[SY_TMS] ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_next = pins_s[SY_TMS] ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = pins_s[SY_TMS] ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = pins_s[SY_TMS] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_next = pins_s[SY_TMS] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_next = pins_s[SY_TMS] ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = pins_s[SY_TMS] ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_next = pins_s[SY_TMS] ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_next = pins_s[SY_TMS] ? TAP_SEL_DR : TAP_IDLE;
         endcase
      end
   end

   // Instruction and bypass paths; tdo changes on the falling tck edge
   always_comb begin
      ir_shift_next = ir_shift_reg;
      ir_next = ir_reg;
      bypass_next = bypass_reg;
      tdo_next = tdo_reg;
      tdo_oe_next = tdo_oe_reg;
      if (tck_rise) begin
         unique case (tap_reg)
            TAP_RESET: ir_next = OPC_BYPASS;
            TAP_CAP_IR: ir_shift_next = IR_CAPTURE_VAL;
            TAP_SHIFT_IR: ir_shift_next = {pins_s[SY_TDI], ir_shift_reg[IR_LEN-1:1]};
            TAP_UPD_IR: ir_next = ir_shift_reg;
            TAP_CAP_DR: bypass_next = 1'b0;
            TAP_SHIFT_DR: bypass_next = pins_s[SY_TDI];
            default: ;
         endcase
      end
      if (tck_fall) begin
         tdo_oe_next = (tap_reg == TAP_SHIFT_IR) || (tap_reg == TAP_SHIFT_DR);
         tdo_next = (tap_reg == TAP_SHIFT_IR) ? ir_shift_reg[0] : bypass_reg;
      end
   end

   // Enable latch and the source it steers
   always_comb begin
      user_en_next = user_en_reg;
      src_user_next = src_user_reg;
      tail_next = tail_reg;
      if (pins_s[SY_POR]) begin
         user_en_next = 1'b0;
         src_user_next = 1'b0;
         tail_next = 4'h0;
      end else begin
         if (upd_ir && ir_shift_reg == OPC_SELECT_USER && pins_s[SY_OSC]) begin
            user_en_next = 1'b1;
         end else if (upd_ir && ir_shift_reg == OPC_REVERT_OSC) begin
            user_en_next = 1'b0;
            if (user_en_reg) begin
               tail_next = REVERT_TAIL_EDGES;
            end
         end
         // Other opcodes leave the latch alone
         if (user_en_reg) begin
            src_user_next = 1'b1;
         end else if (src_user_reg && uclk_rise) begin
            // Switchover needs user clock edges; a stopped pin holds it
            if (tail_reg <= 4'h1) begin
               src_user_next = 1'b0;
               tail_next = 4'h0;
            end else begin
               tail_next = tail_reg - 4'h1;
            end
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tck_prev_reg <= 1'b0;
         uclk_prev_reg <= 1'b0;
         tap_reg <= TAP_RESET;
         ir_shift_reg <= IR_CAPTURE_VAL;
         ir_reg <= OPC_BYPASS;
         bypass_reg <= 1'b0;
         tdo_reg <= 1'b0;
         tdo_oe_reg <= 1'b0;
         user_en_reg <= 1'b0;
         src_user_reg <= 1'b0;
         tail_reg <= 4'h0;
      end else begin
         tck_prev_reg <= tck_prev_next;
         uclk_prev_reg <= uclk_prev_next;
         tap_reg <= tap_next;
         ir_shift_reg <= ir_shift_next;
         ir_reg <= ir_next;
         bypass_reg <= bypass_next;
         tdo_reg <= tdo_next;
         tdo_oe_reg <= tdo_oe_next;
         user_en_reg <= user_en_next;
         src_user_reg <= src_user_next;
         tail_reg <= tail_next;
      end
   end

   assign tck_prev_next = pins_s[SY_TCK];
   assign uclk_prev_next = pins_s[SY_UCLK];
   assign tdo = tdo_reg;
   assign tdo_oe = tdo_oe_reg;
   assign user_clk_latch = user_en_reg;
   assign clk_src_user = src_user_reg;

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   a_select_takes_user: assert property (
      upd_ir && ir_shift_reg == OPC_SELECT_USER && pins_s[SY_OSC] && !pins_s[SY_POR]
      |=> user_en_reg ##1 src_user_reg)
      else $error("select instruction did not switch to user clock");

   a_osc_off_blocks: assert property (
      upd_ir && ir_shift_reg == OPC_SELECT_USER && !pins_s[SY_OSC] && !user_en_reg
      |=> !user_en_reg)
      else $error("select took effect with oscillator disabled");

   a_other_instr_keeps: assert property (
      upd_ir && ir_shift_reg != OPC_REVERT_OSC && user_en_reg && !pins_s[SY_POR]
      |=> user_en_reg ##1 src_user_reg)
      else $error("other instruction undid user clock selection");

   a_only_revert_por: assert property (
      $fell(user_en_reg) |-> $past(pins_s[SY_POR]) ||
      ($past(upd_ir) && $past(ir_shift_reg) == OPC_REVERT_OSC))
      else $error("latch cleared without revert or power-on reset");

   a_revert_clears: assert property (
      upd_ir && ir_shift_reg == OPC_REVERT_OSC |=> !user_en_reg)
      else $error("revert instruction did not clear latch");

   a_tail_edges: assert property (
      $fell(src_user_reg) |-> $past(pins_s[SY_POR]) ||
      ($past(tail_reg) <= 4'h1 && $past(uclk_rise) && !$past(user_en_reg)))
      else $error("source left user clock before tail edges");

   a_latch_at_update: assert property (
      !$stable(user_en_reg) |-> $past(upd_ir) || $past(pins_s[SY_POR]))
      else $error("latch changed outside Update-IR");

   a_ir_commit: assert property (
      upd_ir |=> ir_reg == $past(ir_shift_reg))
      else $error("instruction not committed in Update-IR");

   a_tail_load: assert property (
      upd_ir && ir_shift_reg == OPC_REVERT_OSC && user_en_reg && !pins_s[SY_POR]
      |=> tail_reg == REVERT_TAIL_EDGES && src_user_reg)
      else $error("revert did not arm the tail count");

   a_tail_step: assert property (
      !pins_s[SY_POR] && !user_en_reg && src_user_reg && uclk_rise && tail_reg > 4'h1
      |=> src_user_reg && tail_reg == $past(tail_reg) - 4'h1)
      else $error("tail count did not step on a user clock rise");

   a_por_clears: assert property (
      pins_s[SY_POR] |=> !user_en_reg && !src_user_reg && tail_reg == 4'h0)
      else $error("power-on reset did not return to oscillator");
endmodule : clock_source_select

// ### tb/jtag_host_model.sv
module jtag_host_model
   import clksel_pkg::*;
(
   input wire logic clock, // Paces the pins
   input wire logic tdo, // Test data from the device
   output logic tck, // Test clock, still between frames
   output logic tms, // Test mode select
   output logic tdi // Test data, idles high as if pulled up
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // One test clock cycle, 40 ns a phase; tdo is taken just before the rise
   task automatic step(input logic m, input logic d, output logic seen);
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge clock);
      seen = tdo;
      tck <= 1'b1;
      repeat (4) @(posedge clock);
      tck <= 1'b0;
   endtask : step
   task automatic tap_reset();
      logic b;
      repeat (5) step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
   endtask : tap_reset
   // Idle to Idle through Update-IR, opcode LSB first
   task automatic load_ir(input logic [IR_LEN-1:0] opc, output logic [IR_LEN-1:0] cap);
      logic b;
      step(1'b1, 1'b1, b);
      step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
      step(1'b0, 1'b1, b);
      for (int i = 0; i < IR_LEN; i++) begin
         step(i == IR_LEN - 1, opc[i], b);
         cap[i] = b;
      end
      step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
   endtask : load_ir
   // Idle to Idle through the data path, data LSB first
   task automatic scan_dr(input logic [IR_LEN-1:0] din, output logic [IR_LEN-1:0] dout);
      logic b;
      step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
      step(1'b0, 1'b1, b);
      for (int i = 0; i < IR_LEN; i++) begin
         step(i == IR_LEN - 1, din[i], b);
         dout[i] = b;
      end
      step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
   endtask : scan_dr
endmodule : jtag_host_model

// ### tb/jtag_clock_source_select_tb_top.sv
module jtag_clock_source_select_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import clksel_pkg::*;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic uclk = 1'b0;
   logic osc_enable = 1'b0;
   logic por = 1'b0;
   logic tck, tms, tdi, tdo, tdo_oe, latch, src;
   logic [IR_LEN-1:0] r;
   logic [IR_LEN-1:0] dr_in;
   int oe_cycles = 0;
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;
   int exp_latch = 0;
   int exp_src = 0;
   int tail_left = 0;

   always #5 clock = ~clock;

   clock_source_select dut (.clock(clock), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
      .user_clock_pin(uclk), .osc_enable(osc_enable), .por(por), .tdo(tdo), .tdo_oe(tdo_oe),
      .user_clk_latch(latch), .clk_src_user(src));
   // Released tdo reads as pulled up
   jtag_host_model host (.clock(clock), .tdo(tdo_oe ? tdo : 1'b1), .tck(tck), .tms(tms),
      .tdi(tdi));

   task automatic give_verdict();
      if (n_errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input logic [IR_LEN-1:0] seen, input logic [IR_LEN-1:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic compare();
      repeat (8) @(posedge clock);
      check(IR_LEN'(latch), IR_LEN'(exp_latch[0]));
      check(IR_LEN'(src), IR_LEN'(exp_src[0]));
   endtask : compare

   task automatic issue(input logic [IR_LEN-1:0] opc);
      logic [IR_LEN-1:0] cap;
      int oe_start;
      oe_start = oe_cycles;
      host.load_ir(opc, cap);
      check(cap, IR_CAPTURE_VAL);
      // Drive enable stands for the ten shift steps of eight clocks each
      check(IR_LEN'(oe_cycles - oe_start), IR_LEN'(IR_LEN * 8));
      if (opc == OPC_SELECT_USER && osc_enable) begin
         exp_latch = 1;
         exp_src = 1;
         tail_left = 0;
      end else if (opc == OPC_REVERT_OSC) begin
         if (exp_latch == 1) tail_left = 10;
         exp_latch = 0;
      end
      compare();
   endtask : issue

   // Board user clock, 80 ns period, only for the counted rises
   task automatic pulse_uclk(input int n);
      repeat (n) begin
         repeat (4) @(posedge clock);
         uclk <= 1'b1;
         repeat (4) @(posedge clock);
         uclk <= 1'b0;
         if (tail_left > 0) tail_left--;
         if (tail_left == 0 && exp_latch == 0) exp_src = 0;
      end
      compare();
   endtask : pulse_uclk

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (tdo_oe === 1'b1) begin
         oe_cycles <= oe_cycles + 1;
      end
      if (cycles == 20000) begin
         n_errors++;
         give_verdict();
      end
   end

   initial begin
      void'($urandom(32'he171));
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      compare();
      check(IR_LEN'(tdo_oe), 10'h000);
      host.tap_reset();
      issue(OPC_SELECT_USER);
      osc_enable <= 1'b1;
      issue(OPC_SELECT_USER);
      for (int i = 0; i < 4; i++) begin
         r = IR_LEN'($urandom);
         if (r == OPC_SELECT_USER || r == OPC_REVERT_OSC) r = OPC_BYPASS;
         issue(r);
      end
      // Data scan through the one-bit bypass, latch must survive it
      dr_in = IR_LEN'($urandom);
      host.scan_dr(dr_in, r);
      check(r, {dr_in[IR_LEN-2:0], 1'b0});
      compare();
      host.tap_reset();
      compare();
      // Revert, then ten user clock rises: the source must wait for the tail
      issue(OPC_REVERT_OSC);
      pulse_uclk(9);
      pulse_uclk(1);
      issue(OPC_SELECT_USER);
      por <= 1'b1;
      repeat (8) @(posedge clock);
      por <= 1'b0;
      exp_latch = 0;
      exp_src = 0;
      compare();
      issue(OPC_REVERT_OSC);
      pulse_uclk(10);
      issue(OPC_SELECT_USER);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      exp_latch = 0;
      exp_src = 0;
      compare();
      host.tap_reset();
      issue(OPC_SELECT_USER);
      give_verdict();
   end
endmodule : jtag_clock_source_select_tb_top
